// File: src/clk_mon_pkg.sv
// Purpose: Shared constants and carriers for the clock status and PLL monitor bank.
// Assumes: Byte-wide register access at the documented offsets.
// Notes: The fractional multiplier spans two bytes, upper six bits first.
package clk_mon_pkg;
   localparam logic [7:0] OFF_EVENT_FLAGS = 8'h5F;
   localparam logic [7:0] OFF_IN_DIV = 8'h60;
   localparam logic [7:0] OFF_INT_MULT = 8'h61;
   localparam logic [7:0] OFF_FRAC_HI = 8'h62;
   localparam logic [7:0] OFF_FRAC_LO = 8'h63;
   localparam int BIT_HALT = 4;
   localparam int BIT_ABSENT = 2;
   localparam int BIT_RESYNC = 1;
   localparam int BIT_FAULT = 0;
   localparam int FRAC_HI_LSB = 8;
   localparam logic [13:0] FRAC_MAX = 14'h270F;
   localparam logic [13:0] FRAC_SCALE = 14'h2710;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] SYNC_RESET = 2'h0;
   // Cycles with both serial clock lines low and still before they count as absent.
   localparam logic [15:0] IDLE_LIMIT = 16'h0400;

   typedef struct packed {
      logic [6:0] in_div_m1;
      logic [5:0] int_mult;
      logic [13:0] frac_mult;
   } pll_set_s;

   typedef struct packed {
      logic rd;
      logic [7:0] addr;
   } reg_req_s;
endpackage

// File: src/clk_sync2.sv
// Purpose: Two-flop synchroniser for one level from outside the clock domain.
// Assumes: Input is a slowly changing level.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
module clk_sync2 (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Level in and out
   input wire logic din,
   output logic dout
);
   import clk_mon_pkg::*;
   logic [1:0] sync_ff;
   logic [1:0] nxt_sync;

   always_comb begin
      nxt_sync = {sync_ff[0], din};
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sync_ff <= SYNC_RESET;
      end else begin
         sync_ff <= nxt_sync;
      end
   end

   assign dout = sync_ff[1];
endmodule

// File: src/clock_status_pll_monitor_regs.sv
// Purpose: Clock event flags and PLL in-use monitor registers, read over the control port.
// Assumes: Event strobes and PLL settings come from logic on CLOCK; clock levels are pins.
// Notes: Sticky flags clear on a read of the event flags register; a same-cycle event keeps them set.
`timescale 1ns/1ps
module clock_status_pll_monitor_regs (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic SYS_RST,
   // Register read port
   input wire clk_mon_pkg::reg_req_s REG_REQ,
   output logic [7:0] REG_RDATA,
   // Clock status sources
   input wire logic MCLK_HALT_EVT,
   input wire logic CLK_FAULT_EVT,
   input wire logic RESYNC_ACTIVE,
   input wire logic FRAME_CLK_PIN,
   input wire logic BIT_CLK_PIN,
   // PLL settings
   input wire logic AUTO_SET_EN,
   input wire clk_mon_pkg::pll_set_s PLL_AUTO,
   input wire clk_mon_pkg::pll_set_s PLL_PROG,
   // Decoded monitor views
   output logic [6:0] PLL_IN_DIVIDER_VIEW,
   output logic [5:0] PLL_INT_MULT_VIEW,
   output logic [13:0] PLL_FRAC_MULT_VIEW,
   output logic PLL_SETTING_ERR
);
   import clk_mon_pkg::*;

   // ------------------------------------------------------------
   // Pin synchronisers and toggle watch
   // ------------------------------------------------------------
   logic frame_s;
   logic bit_s;
   logic frame_d_ff;
   logic bit_d_ff;
   logic nxt_frame_d;
   logic nxt_bit_d;
   logic [15:0] idle_cnt_ff;
   logic [15:0] nxt_idle_cnt;
   logic serial_clocks_absent;

   clk_sync2 u_sync_frame (
      .clk(CLOCK),
      .rst(SYS_RST),
      .din(FRAME_CLK_PIN),
      .dout(frame_s)
   );

   clk_sync2 u_sync_bit (
      .clk(CLOCK),
      .rst(SYS_RST),
      .din(BIT_CLK_PIN),
      .dout(bit_s)
   );

   // Absent means both lines held low with no edge for IDLE_LIMIT cycles.
   always_comb begin
      nxt_frame_d = frame_s;
      nxt_bit_d = bit_s;
      if (frame_s || bit_s || (frame_s != frame_d_ff) || (bit_s != bit_d_ff)) begin
         nxt_idle_cnt = 16'h0000;
      end else if (idle_cnt_ff != IDLE_LIMIT) begin
         nxt_idle_cnt = idle_cnt_ff + 16'h0001;
      end else begin
         nxt_idle_cnt = idle_cnt_ff;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         frame_d_ff <= 1'b0;
         bit_d_ff <= 1'b0;
         idle_cnt_ff <= 16'h0000;
      end else begin
         frame_d_ff <= nxt_frame_d;
         bit_d_ff <= nxt_bit_d;
         idle_cnt_ff <= nxt_idle_cnt;
      end
   end

   assign serial_clocks_absent = (idle_cnt_ff == IDLE_LIMIT);

   // ------------------------------------------------------------
   // Event flags and monitor views
   // ------------------------------------------------------------
   logic sticky_master_clock_halt_ff;
   logic sticky_clock_fault_ff;
   logic nxt_halt;
   logic nxt_fault;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic [6:0] in_div_ff;
   logic [5:0] int_ff;
   logic [13:0] frac_ff;
   logic err_ff;
   pll_set_s pll_sel;
   logic flags_read;

   assign flags_read = REG_REQ.rd && (REG_REQ.addr == OFF_EVENT_FLAGS);

   always_comb begin
      pll_sel = AUTO_SET_EN ? PLL_AUTO : PLL_PROG;
      nxt_halt = MCLK_HALT_EVT || (sticky_master_clock_halt_ff && !flags_read);
      nxt_fault = CLK_FAULT_EVT || (sticky_clock_fault_ff && !flags_read);
      nxt_rdata = rdata_ff;
      if (REG_REQ.rd) begin
         case (REG_REQ.addr)
            OFF_EVENT_FLAGS: begin
               nxt_rdata = RESET_BYTE;
               nxt_rdata[BIT_HALT] = sticky_master_clock_halt_ff;
               nxt_rdata[BIT_ABSENT] = serial_clocks_absent;
               nxt_rdata[BIT_RESYNC] = RESYNC_ACTIVE;
               nxt_rdata[BIT_FAULT] = sticky_clock_fault_ff;
            end
            OFF_IN_DIV: nxt_rdata = {1'b0, in_div_ff};
            OFF_INT_MULT: nxt_rdata = {2'b00, int_ff};
            OFF_FRAC_HI: nxt_rdata = {2'b00, frac_ff[13:FRAC_HI_LSB]};
            OFF_FRAC_LO: nxt_rdata = frac_ff[FRAC_HI_LSB-1:0];
            default: nxt_rdata = RESET_BYTE;
         endcase
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         sticky_master_clock_halt_ff <= 1'b0;
         sticky_clock_fault_ff <= 1'b0;
         rdata_ff <= RESET_BYTE;
         in_div_ff <= 7'h00;
         int_ff <= 6'h00;
         frac_ff <= 14'h0000;
         err_ff <= 1'b0;
      end else begin
         sticky_master_clock_halt_ff <= nxt_halt;
         sticky_clock_fault_ff <= nxt_fault;
         rdata_ff <= nxt_rdata;
         in_div_ff <= pll_sel.in_div_m1;
         int_ff <= pll_sel.int_mult;
         frac_ff <= pll_sel.frac_mult;
         // Setting is unusable when J is zero or D reaches the scale (J + D/10000, times R).
         err_ff <= (pll_sel.int_mult == 6'h00) || (pll_sel.frac_mult > FRAC_MAX);
      end
   end

   assign REG_RDATA = rdata_ff;
   assign PLL_IN_DIVIDER_VIEW = in_div_ff;
   assign PLL_INT_MULT_VIEW = int_ff;
   assign PLL_FRAC_MULT_VIEW = frac_ff;
   assign PLL_SETTING_ERR = err_ff;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_halt_set;
      @(posedge CLOCK) disable iff (SYS_RST)
      MCLK_HALT_EVT |=> sticky_master_clock_halt_ff;
   endproperty
   a_halt_set: assert property (p_halt_set) else $error("halt flag not set");

   property p_halt_clear;
      @(posedge CLOCK) disable iff (SYS_RST)
      (flags_read && !MCLK_HALT_EVT) |=> !sticky_master_clock_halt_ff;
   endproperty
   a_halt_clear: assert property (p_halt_clear) else $error("halt not cleared");

   property p_absent;
      @(posedge CLOCK) disable iff (SYS_RST)
      (REG_REQ.rd && REG_REQ.addr == OFF_EVENT_FLAGS) |=> REG_RDATA[2] == $past(serial_clocks_absent);
   endproperty
   a_absent: assert property (p_absent) else $error("absent bit wrong");

   property p_resync;
      @(posedge CLOCK) disable iff (SYS_RST)
      (REG_REQ.rd && REG_REQ.addr == OFF_EVENT_FLAGS) |=> REG_RDATA[1] == $past(RESYNC_ACTIVE);
   endproperty
   a_resync: assert property (p_resync) else $error("resync bit wrong");

   property p_fault_hold;
      @(posedge CLOCK) disable iff (SYS_RST)
      (sticky_clock_fault_ff && !flags_read) |=> sticky_clock_fault_ff;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault flag lost");

   property p_same_cycle;
      @(posedge CLOCK) disable iff (SYS_RST)
      (flags_read && CLK_FAULT_EVT) |=> sticky_clock_fault_ff;
   endproperty
   a_same_cycle: assert property (p_same_cycle) else $error("event lost on read");

   property p_view_sel;
      @(posedge CLOCK) disable iff (SYS_RST)
      AUTO_SET_EN |=> PLL_INT_MULT_VIEW == $past(PLL_AUTO.int_mult);
   endproperty
   a_view_sel: assert property (p_view_sel) else $error("auto view wrong");

   property p_frac_lo;
      @(posedge CLOCK) disable iff (SYS_RST)
      (REG_REQ.rd && REG_REQ.addr == OFF_FRAC_LO) |=> REG_RDATA == $past(frac_ff[7:0]);
   endproperty
   a_frac_lo: assert property (p_frac_lo) else $error("frac low byte wrong");

   property p_fault_clear;
      @(posedge CLOCK) disable iff (SYS_RST)
      (flags_read && !CLK_FAULT_EVT) |=> !sticky_clock_fault_ff;
   endproperty
   a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");

   property p_halt_same;
      @(posedge CLOCK) disable iff (SYS_RST)
      (flags_read && MCLK_HALT_EVT) |=> sticky_master_clock_halt_ff;
   endproperty
   a_halt_same: assert property (p_halt_same) else $error("halt lost on read");
endmodule

// File: verification/clock_status_pll_monitor_regs_tb_top.sv
// Purpose: Self-checking bench for the clock status and PLL monitor register bank.
// Assumes: Reads are one-cycle strobes and their data is looked at one cycle later.
// Notes: The frame clock pin toggles unless a test wants the serial clocks absent.
`timescale 1ns/1ps
module clock_status_pll_monitor_regs_tb_top;
   import clk_mon_pkg::*;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   reg_req_s req = '0;
   logic [7:0] rdata;
   logic halt = 1'b0;
   logic fault = 1'b0;
   logic resync = 1'b0;
   logic frame_clk = 1'b0;
   logic bit_clk = 1'b0;
   logic tog = 1'b1;
   logic btog = 1'b0;
   logic auto_en = 1'b0;
   pll_set_s pll_auto = '0;
   pll_set_s pll_prog = '0;
   logic [6:0] div_view;
   logic [5:0] int_view;
   logic [13:0] frac_view;
   logic set_err;
   int failures = 0;
   int checked = 0;
   always #5 clock = ~clock;
   always @(negedge clock) frame_clk <= tog ? ~frame_clk : 1'b0;
   always @(negedge clock) bit_clk <= btog ? ~bit_clk : 1'b0;
   clock_status_pll_monitor_regs DUT (
      .CLOCK(clock), .SYS_RST(sys_rst), .REG_REQ(req), .REG_RDATA(rdata),
      .MCLK_HALT_EVT(halt), .CLK_FAULT_EVT(fault), .RESYNC_ACTIVE(resync),
      .FRAME_CLK_PIN(frame_clk), .BIT_CLK_PIN(bit_clk), .AUTO_SET_EN(auto_en),
      .PLL_AUTO(pll_auto), .PLL_PROG(pll_prog), .PLL_IN_DIVIDER_VIEW(div_view),
      .PLL_INT_MULT_VIEW(int_view), .PLL_FRAC_MULT_VIEW(frac_view),
      .PLL_SETTING_ERR(set_err));
   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      @(negedge clock);
      req.rd = 1'b1;
      req.addr = addr;
      @(negedge clock);
      req.rd = 1'b0;
      checked++;
      if (rdata !== exp) begin
         failures++;
         $display("mismatch read %h expected %h seen %h", addr, exp, rdata);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge clock);
      s = 1'b1;
      @(negedge clock);
      s = 1'b0;
   endtask
   task automatic conclude();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      conclude();
   end
   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      pll_set_s tbl [3];
      pll_set_s sel;
      logic exp_err;
      tbl[0] = '{7'h7F, 6'h3F, 14'h270F};
      tbl[1] = '{7'h00, 6'h00, 14'h0000};
      tbl[2] = '{7'h2A, 6'h15, 14'h2710};
      repeat (16) @(negedge clock);
      sys_rst = 1'b0;
      rd(OFF_EVENT_FLAGS, 8'h00);
      rd(8'h64, 8'h00);
      rd(8'h5E, 8'h00);
      pulse(halt);
      rd(OFF_EVENT_FLAGS, 8'h10);
      rd(OFF_EVENT_FLAGS, 8'h00);
      pulse(fault);
      rd(OFF_EVENT_FLAGS, 8'h01);
      rd(OFF_EVENT_FLAGS, 8'h00);
      // A halt and a fault that land with the clearing read must survive it.
      @(negedge clock);
      req.rd = 1'b1;
      req.addr = OFF_EVENT_FLAGS;
      halt = 1'b1;
      fault = 1'b1;
      @(negedge clock);
      req.rd = 1'b0;
      halt = 1'b0;
      fault = 1'b0;
      chk("same cycle read", 14'h0000, {6'h00, rdata});
      rd(OFF_EVENT_FLAGS, 8'h11);
      // The resync bit is live, so the very next read already shows it.
      resync = 1'b1;
      rd(OFF_EVENT_FLAGS, 8'h02);
      rd(OFF_EVENT_FLAGS, 8'h02);
      resync = 1'b0;
      rd(OFF_EVENT_FLAGS, 8'h00);
      rd(OFF_EVENT_FLAGS, 8'h00);
      tog = 1'b0;
      repeat (IDLE_LIMIT - 16'h0008) @(negedge clock);
      rd(OFF_EVENT_FLAGS, 8'h00);
      repeat (24) @(negedge clock);
      rd(OFF_EVENT_FLAGS, 8'h04);
      btog = 1'b1;
      repeat (6) @(negedge clock);
      rd(OFF_EVENT_FLAGS, 8'h00);
      btog = 1'b0;
      tog = 1'b1;
      repeat (6) @(negedge clock);
      rd(OFF_EVENT_FLAGS, 8'h00);
      for (int i = 0; i < 3; i++) begin
         for (int s = 0; s < 2; s++) begin
            pll_auto = tbl[i];
            pll_prog = tbl[(i + 1) % 3];
            auto_en = s[0];
            sel = s[0] ? tbl[i] : tbl[(i + 1) % 3];
            exp_err = (sel.int_mult == 6'h00) || (sel.frac_mult > FRAC_MAX);
            repeat (4) @(negedge clock);
            chk("divider view", {7'h00, sel.in_div_m1}, {7'h00, div_view});
            chk("integer view", {8'h00, sel.int_mult}, {8'h00, int_view});
            chk("fraction view", sel.frac_mult, frac_view);
            chk("setting error", {13'h0000, exp_err}, {13'h0000, set_err});
            rd(OFF_IN_DIV, {1'b0, sel.in_div_m1});
            rd(OFF_INT_MULT, {2'h0, sel.int_mult});
            rd(OFF_FRAC_HI, {2'h0, sel.frac_mult[13:8]});
            rd(OFF_FRAC_LO, sel.frac_mult[7:0]);
         end
      end
      conclude();
   end
endmodule
